//--- core/store_subtract_exec.sv
// Execute unit for the indexed long store, byte/word/phrase stores and subtract group.
// Assumes a register file with two combinational read ports and one write port,
// and a memory bus that takes one write request per cycle while mem_ready is high.
`timescale 1ns/10ps
`default_nettype none
module store_subtract_exec
   import store_subtract_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Instruction issue
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic index_sel_b,
   output logic instr_ready,
   // Register file read ports
   output logic [4:0] rd_addr_a,
   output logic rd_en_a,
   input wire logic [31:0] rd_data_a,
   output logic [4:0] rd_addr_b,
   output logic rd_en_b,
   input wire logic [31:0] rd_data_b,
   // Register file write port
   output logic wr_en,
   output logic [4:0] wr_addr,
   output logic [31:0] wr_data,
   // High-half register for phrase stores
   input wire logic [31:0] high_half,
   // Memory write bus
   input wire logic mem_ready,
   input wire logic mem_is_internal,
   output logic mem_wr,
   output logic [31:0] mem_addr,
   output logic [63:0] mem_wdata,
   output logic [1:0] mem_size,
   // Flags
   output logic flag_zero,
   output logic flag_neg,
   output logic flag_carry
);

   logic rst_meta_r;
   logic rst_sync_r;
   exec_state_e state_r;
   exec_state_e state_nxt;
   logic [5:0] op_r;
   logic [4:0] src_r;
   logic [4:0] dst_r;
   logic [31:0] addr_hold_r;
   logic [31:0] diff_r;
   logic borrow_r;
   logic [5:0] opc;
   logic [4:0] src_f;
   logic [4:0] dst_f;
   logic is_sub;
   logic is_narrow;
   logic is_index;
   logic take;
   logic [31:0] subtrahend;
   logic [32:0] diff_full;

   // Subtract walk, first cycle:
   // Both operands read on the take edge
   // Immediate form reads only the destination
   // Difference and borrow captured at once

   // Subtract walk, second cycle:
   // Result parked in diff_r
   // Port B enabled on the captured source field
   // New instructions refused

   // Subtract walk, third cycle:
   // Write-back and flag update on one edge
   // Write strobe stands for one cycle
   // Issue reopens on the next edge

   // Indexed store walk, first cycle:
   // Index base on port B
   // Destination on port A
   // Sum kept as the bus address

   // Indexed store walk, second cycle:
   // Source register read on port B
   // Its value becomes the store data
   // Request raised on the closing edge

   // Narrow store walk:
   // Address from port B, data from port A
   // Request raised on the take edge
   // Back to back while the bus keeps up

   // Bus hazards:
   // A stalled request blocks new issue
   // Request fields frozen while stalled
   // Internal targets always take a long write

   // Flag hazards:
   // Borrow in is the carry of the last subtract
   // Stores never touch the flags
   // Next subtract waits for the flag update

   // Limitations:
   // Unknown opcodes are left untaken
   // Alignment is left to software
   // No write-back ordering against the bus

   // True for the register-indexed long store opcode
   function automatic logic op_is_index(input logic [5:0] code);
      op_is_index = (code == OP_INDEX_B_WRITE);
   endfunction : op_is_index


   // Subtraction with borrow in; bit 32 is borrow out
   function automatic logic [32:0] sub_borrow(input logic [31:0] a, input logic [31:0] b,
                                              input logic bin);
      sub_borrow = {1'b0, a} - {1'b0, b} - {32'h00000000, bin};
   endfunction : sub_borrow

   // Reset release through two flip-flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Instruction field decode
   assign opc = instr_word[OPC_HI:OPC_LO];
   assign src_f = instr_word[SRC_HI:SRC_LO];
   assign dst_f = instr_word[DST_HI:DST_LO];
   assign is_sub = (opc == OP_DIFF) || (opc == OP_BORROW_DIFF) || (opc == OP_IMM_DIFF);
   assign is_narrow = (opc == OP_BYTE_WRITE) || (opc == OP_WORD_WRITE) ||
                      (opc == OP_PHRASE_WRITE);
   assign is_index = op_is_index(opc);
   assign instr_ready = (state_r == ST_IDLE) && !(mem_wr && !mem_ready);
   assign take = instr_valid && instr_ready && (is_sub || is_narrow || is_index);

   // Register read port steering per cycle
   always_comb begin
      rd_en_a = 1'b0;
      rd_en_b = 1'b0;
      rd_addr_a = dst_f;
      rd_addr_b = src_f;
      if (state_r == ST_CYC2) begin
         rd_en_b = 1'b1;
         rd_addr_b = src_r;
      end else if (take) begin
         if (is_index) begin
            rd_en_a = 1'b1;
            rd_en_b = 1'b1;
            rd_addr_b = index_sel_b ? REG_INDEX_B : REG_INDEX_A;
         end else if (opc == OP_IMM_DIFF) begin
            rd_en_a = 1'b1;
         end else begin
            rd_en_a = 1'b1;
            rd_en_b = 1'b1;
         end
      end
   end

   // Subtrahend: register or immediate 1-32, zero field meaning 32
   assign subtrahend = (opc == OP_IMM_DIFF) ? ((src_f == 5'h00) ? 32'h00000020 :
                       {27'h0000000, src_f}) : rd_data_b;
   assign diff_full = sub_borrow(rd_data_a, subtrahend,
                                 (opc == OP_BORROW_DIFF) && flag_carry);

   // Sequencer state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (take && is_index) begin
               state_nxt = ST_CYC2;
            end else if (take && is_sub) begin
               state_nxt = ST_CYC2;
            end
         end
         ST_CYC2: state_nxt = op_is_index(op_r) ? ST_IDLE : ST_CYC3;
         ST_CYC3: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Capture of instruction fields and first-cycle results
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         op_r <= 6'h00;
         src_r <= 5'h00;
         dst_r <= 5'h00;
         addr_hold_r <= ZERO_WORD;
         diff_r <= ZERO_WORD;
         borrow_r <= 1'b0;
      end else if (take) begin
         op_r <= opc;
         src_r <= src_f;
         dst_r <= dst_f;
         addr_hold_r <= rd_data_a + rd_data_b;
         diff_r <= diff_full[31:0];
         borrow_r <= diff_full[32];
      end
   end

   // Destination write-back in the third cycle
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         wr_en <= 1'b0;
         wr_addr <= 5'h00;
         wr_data <= ZERO_WORD;
      end else begin
         wr_en <= (state_r == ST_CYC2) && !op_is_index(op_r);
         wr_addr <= dst_r;
         wr_data <= diff_r;
      end
   end

   // Flags updated only by subtracts
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         flag_zero <= 1'b0;
         flag_neg <= 1'b0;
         flag_carry <= 1'b0;
      end else if (state_r == ST_CYC2 && !op_is_index(op_r)) begin
         flag_zero <= (diff_r == ZERO_WORD);
         flag_neg <= diff_r[31];
         flag_carry <= borrow_r;
      end
   end

   // Memory write requests, held until accepted
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         mem_wr <= 1'b0;
         mem_addr <= ZERO_WORD;
         mem_wdata <= {ZERO_WORD, ZERO_WORD};
         mem_size <= SIZE_LONG;
      end else if (mem_wr && !mem_ready) begin
         mem_wr <= 1'b1;
      end else if (state_r == ST_CYC2 && op_is_index(op_r)) begin
         mem_wr <= 1'b1;
         mem_addr <= addr_hold_r;
         mem_wdata <= {ZERO_WORD, rd_data_b};
         mem_size <= SIZE_LONG;
      end else if (take && is_narrow) begin
         mem_wr <= 1'b1;
         mem_addr <= rd_data_b;
         if (mem_is_internal) begin
            mem_wdata <= {ZERO_WORD, rd_data_a};
            mem_size <= SIZE_LONG;
         end else if (opc == OP_BYTE_WRITE) begin
            mem_wdata <= {ZERO_WORD, 24'h000000, rd_data_a[7:0]};
            mem_size <= SIZE_BYTE;
         end else if (opc == OP_WORD_WRITE) begin
            mem_wdata <= {ZERO_WORD, 16'h0000, rd_data_a[15:0]};
            mem_size <= SIZE_WORD;
         end else begin
            mem_wdata <= {high_half, rd_data_a};
            mem_size <= SIZE_PHRASE;
         end
      end else begin
         mem_wr <= 1'b0;
      end
   end

endmodule : store_subtract_exec
`default_nettype wire

//--- pkg/store_subtract_pkg.sv
// Constants for the store and subtract execute block.
// Assumes a 32-register file and a 16-bit instruction word of opcode, source and dest fields.
package store_subtract_pkg;
   localparam logic [5:0] OP_DIFF = 6'h04;
   localparam logic [5:0] OP_BORROW_DIFF = 6'h05;
   localparam logic [5:0] OP_IMM_DIFF = 6'h06;
   localparam logic [5:0] OP_BYTE_WRITE = 6'h2D;
   localparam logic [5:0] OP_WORD_WRITE = 6'h2E;
   localparam logic [5:0] OP_PHRASE_WRITE = 6'h30;
   localparam logic [5:0] OP_INDEX_B_WRITE = 6'h3D;
   localparam logic [4:0] REG_INDEX_A = 5'h0E;
   localparam logic [4:0] REG_INDEX_B = 5'h0F;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 10;
   localparam int SRC_HI = 9;
   localparam int SRC_LO = 5;
   localparam int DST_HI = 4;
   localparam int DST_LO = 0;
   // Bus write sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;
   localparam logic [1:0] SIZE_PHRASE = 2'h3;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   typedef enum logic [1:0] {ST_IDLE, ST_CYC2, ST_CYC3} exec_state_e;
endpackage : store_subtract_pkg

//--- verification/mem_model.sv
// Memory bus responder: always ready, or slow when told to stall.
// Assumes the bench changes stall away from the rising edge.
`timescale 1ns/10ps
`default_nettype none
module mem_model (
   // Bus side
   input wire logic clk_sys,
   input wire logic stall,
   output logic mem_ready
);
   // Slow mode accepts every other cycle
   initial mem_ready = 1'b1;
   always @(negedge clk_sys) mem_ready <= !stall || !mem_ready;
endmodule : mem_model
`default_nettype wire

//--- verification/store_subtract_checker.sv
// Port assertions for the store and subtract execute unit.
// Bound onto store_subtract_exec; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module store_subtract_checker
   import store_subtract_pkg::*;
(
   // Watched ports
   input wire logic clk_sys, resetn, instr_valid, instr_ready, index_sel_b, rd_en_a,
   input wire logic rd_en_b, wr_en, mem_wr, mem_ready, mem_is_internal,
   input wire logic flag_zero, flag_neg, flag_carry,
   input wire logic [15:0] instr_word,
   input wire logic [4:0] rd_addr_a, rd_addr_b, wr_addr,
   input wire logic [31:0] rd_data_a, rd_data_b, wr_data, mem_addr,
   input wire logic [1:0] mem_size
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Decode of the taken instruction
   wire logic [5:0] op = instr_word[15:10];
   wire logic [4:0] dst = instr_word[4:0];
   wire logic tk = instr_valid && instr_ready;
   wire logic sub = tk && op inside {OP_DIFF, OP_BORROW_DIFF, OP_IMM_DIFF};
   wire logic nar = tk && op inside {OP_BYTE_WRITE, OP_WORD_WRITE, OP_PHRASE_WRITE};
   wire logic idx = tk && op == OP_INDEX_B_WRITE;
   wire logic [2:0] flags = {flag_zero, flag_neg, flag_carry};
   a_sub_write_c3:
      assert property (sub |-> ##2 wr_en && wr_addr == $past(dst, 2)) else $error("late write");
   a_sub_reads:
      assert property (sub && op != OP_IMM_DIFF |-> rd_en_b && rd_addr_b == instr_word[9:5]
         && rd_addr_a == dst) else $error("sub reads");
   a_imm_reads:
      assert property (sub && op == OP_IMM_DIFF |-> rd_en_a && !rd_en_b && rd_addr_a == dst)
         else $error("imm reads");
   a_diff_value:
      assert property (tk && op == OP_DIFF |-> ##2 wr_data == $past(rd_data_a, 2)
         - $past(rd_data_b, 2)) else $error("diff value");
   a_flag_result:
      assert property (wr_en |-> flag_zero == (wr_data == ZERO_WORD) && flag_neg == wr_data[31])
         else $error("flags");
   a_store_quiet:
      assert property (nar || idx |=> !wr_en && $stable(flags) ##1 !wr_en && $stable(flags))
         else $error("store side effect");
   a_narrow_addr:
      assert property (nar |=> mem_wr && mem_addr == $past(rd_data_b)) else $error("address");
   a_internal_long:
      assert property (nar && mem_is_internal |=> mem_size == SIZE_LONG) else $error("size");
   a_index_store:
      assert property (idx |-> rd_addr_b == (index_sel_b ? REG_INDEX_B : REG_INDEX_A)
         && rd_addr_a == dst ##1 rd_addr_b == $past(instr_word[9:5]) ##1 mem_wr
         && mem_addr == $past(rd_data_a, 2) + $past(rd_data_b, 2)) else $error("indexed");
   // Main scenarios
   c_borrow: cover property (sub && op == OP_BORROW_DIFF);
   c_internal: cover property (nar && mem_is_internal);
   c_stall: cover property (mem_wr && !mem_ready);
endmodule : store_subtract_checker
bind store_subtract_exec store_subtract_checker u_store_subtract_checker (.*);
`default_nettype wire

//--- verification/tb_top.sv
// Bench: random subtracts and stores against a stalling bus.
// Holds the register file model; uses mem_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import store_subtract_pkg::*;
   logic clk_sys = 0, resetn = 0, instr_valid = 0, index_sel_b = 0, stall = 0, got = 0;
   logic mem_is_internal = 0, instr_ready, rd_en_a, rd_en_b, wr_en, mem_wr, mem_ready;
   logic flag_zero, flag_neg, flag_carry, ec = 0, ez = 0, en = 0;
   logic [15:0] instr_word = 16'h0000;
   logic [5:0] op;
   logic [4:0] rd_addr_a, rd_addr_b, wr_addr, s, d;
   logic [1:0] mem_size, g_size, es;
   logic [31:0] wr_data, mem_addr, g_addr, t, b, imm, ea, high_half = 32'h0, seed = 32'h40B7;
   logic [32:0] r;
   logic [63:0] mem_wdata, g_data;
   logic [31:0] regs [32];
   logic [5:0] ops [7] = '{OP_DIFF, OP_BORROW_DIFF, OP_IMM_DIFF, OP_BYTE_WRITE,
      OP_WORD_WRITE, OP_PHRASE_WRITE, OP_INDEX_B_WRITE};
   int n_errors = 0, check_count = 0, cycles = 0;
   wire logic [31:0] rd_data_a = regs[rd_addr_a];
   wire logic [31:0] rd_data_b = regs[rd_addr_b];
   store_subtract_exec u_store_subtract_exec (.clk_sys(clk_sys), .resetn(resetn),
      .instr_valid(instr_valid), .instr_word(instr_word), .index_sel_b(index_sel_b),
      .instr_ready(instr_ready), .rd_addr_a(rd_addr_a), .rd_en_a(rd_en_a),
      .rd_data_a(rd_data_a), .rd_addr_b(rd_addr_b), .rd_en_b(rd_en_b), .rd_data_b(rd_data_b),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .high_half(high_half),
      .mem_ready(mem_ready), .mem_is_internal(mem_is_internal), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
      .flag_zero(flag_zero), .flag_neg(flag_neg), .flag_carry(flag_carry));
   mem_model u_mem_model (.clk_sys(clk_sys), .stall(stall), .mem_ready(mem_ready));
   always #20 clk_sys = ~clk_sys;
   // Cycle ceiling, register writes and accepted bus writes
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 6000) begin
         n_errors++;
         conclude();
      end
      if (wr_en) regs[wr_addr] <= wr_data;
      if (mem_wr && mem_ready) begin
         got <= 1;
         g_addr <= mem_addr;
         g_data <= mem_wdata;
         g_size <= mem_size;
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [63:0] exp_data(input logic [31:0] dv, sv);
      if (mem_is_internal && op != OP_INDEX_B_WRITE) return {32'h0, dv};
      if (op == OP_BYTE_WRITE) return {56'h0, dv[7:0]};
      if (op == OP_WORD_WRITE) return {48'h0, dv[15:0]};
      if (op == OP_PHRASE_WRITE) return {high_half, dv};
      return {32'h0, sv};
   endfunction : exp_data
   task automatic cmp(input logic [63:0] act, exp);
      check_count++;
      if (act !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, act, exp);
      end
   endtask : cmp
   // Offer one instruction, hold it until taken
   task automatic issue();
      instr_word = {op, s, d};
      instr_valid = 1;
      got = 0;
      #2;
      while (!instr_ready) begin
         @(negedge clk_sys);
         #2;
      end
      @(posedge clk_sys);
      @(negedge clk_sys);
      instr_valid = 0;
   endtask : issue
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      foreach (regs[k]) regs[k] = rnd();
      repeat (12) @(negedge clk_sys);
      resetn = 1;
      repeat (3) @(negedge clk_sys);
      for (int i = 0; i < 120; i++) begin
         @(negedge clk_sys);
         t = rnd();
         high_half = rnd();
         op = ops[t[31:16] % 7];
         {d, s, index_sel_b, mem_is_internal} = t[11:0];
         stall <= t[12];
         imm = (s == 0) ? 32'h20 : {27'h0, s};
         // Early passes force a zero result
         if (i < 8) regs[d] = (op == OP_IMM_DIFF) ? imm : regs[s];
         b = (op == OP_IMM_DIFF) ? imm : regs[s];
         r = {1'b0, regs[d]} - {1'b0, b} - {32'h0, op == OP_BORROW_DIFF && ec};
         ea = (op == OP_INDEX_B_WRITE) ? regs[d] : regs[s];
         if (op == OP_INDEX_B_WRITE) ea = ea + regs[index_sel_b ? REG_INDEX_B : REG_INDEX_A];
         es = (op == OP_INDEX_B_WRITE || mem_is_internal) ? SIZE_LONG : 2'(op - OP_BYTE_WRITE);
         issue();
         if (op < OP_BYTE_WRITE) begin
            {ec, ez, en} = {r[32], r[31:0] == 32'h0, r[31]};
            repeat (3) @(negedge clk_sys);
            cmp(regs[d], r[31:0]);
         end else begin
            repeat (20) if (!got) @(negedge clk_sys);
            cmp(g_addr, ea);
            cmp(g_size, es);
            cmp(g_data, exp_data(regs[d], regs[s]));
         end
         cmp({flag_zero, flag_neg, flag_carry}, {ez, en, ec});
      end
      $display("random mix done");
      conclude();
   end
endmodule : tb_top
`default_nettype wire
